// ---- include/usbh_defs.vh ----
// Constants for the serial transceiver with break, handshake and smart-card modes
`ifndef USBH_DEFS_VH
`define USBH_DEFS_VH
`define USBH_A_CTRL       5'h00
`define USBH_A_MODE       5'h04
`define USBH_A_STATUS     5'h08
`define USBH_A_RXHOLD     5'h0c
`define USBH_A_TXHOLD     5'h10
`define USBH_A_BAUD       5'h14
`define USBH_A_GUARD      5'h18
`define USBH_A_ERRCNT     5'h1c
`define USBH_C_RXEN       0
`define USBH_C_RXDIS      1
`define USBH_C_TXEN       2
`define USBH_C_TXDIS      3
`define USBH_C_CLRSTA     4
`define USBH_C_STTBK      5
`define USBH_C_STPBK      6
`define USBH_C_CLRNACK    7
`define USBH_C_BUFNEW     8
`define USBH_M_MODE_HI    3
`define USBH_M_MODE_LO    0
`define USBH_M_PARODD     4
`define USBH_M_MSB_FIRST_SELECT       5
`define USBH_M_STOP2      6
`define USBH_M_NACK_INHIBIT      7
`define USBH_M_SYNC       8
`define USBH_MODE_NORMAL  4'h0
`define USBH_MODE_HSHAKE  4'h2
`define USBH_MODE_T0      4'h4
`define USBH_MODE_T1      4'h5
`define USBH_S_RX_CHAR_READY      0
`define USBH_S_TX_HOLDING_FREE      1
`define USBH_S_RX_BREAK_FLAG      2
`define USBH_S_FRAME      3
`define USBH_S_PARITY_ERROR_FLAG       4
`define USBH_S_TX_ALL_EMPTY    5
`define USBH_S_NACKI      6
`define USBH_S_CTS        7
`define USBH_S_RXFULL     8
`define USBH_BAUD_RST     16'h000a
`define USBH_BRK_GAP      8'h0c
`define USBH_ERR_MAX      8'hff
`define USBH_OS_LAST      4'hf
`define USBH_OS_MID       4'h7
`define USBH_OS_ENDBRK    4'h1
`define USBH_RESP_OK      2'h0
`define USBH_RESP_ERR     2'h2
`endif

// ---- design/usbh_top.v ----
// Serial transceiver: break, hardware handshake, smart-card T=0/T=1, AXI4-Lite registers
// Overview of operation
// - Break holds line low one character minimum
// - Further start-break ignored until break and its idle gap end
// - Early stop-break still completes full character
// - Break commands need holding free; clear status
// - Lone stop ignored; pending-break writes dropped
// - After break, idle 12 bits or timeguard
// - All-zero frame sets break flag, not framing
// - Line high 2/16 bit ends break (any high at once with sync bit set), flags
// - Handshake mode 0x2, otherwise normal behaviour
// - Request-to-send high: rx disabled and full
// - Clear-to-send high holds next character
// - Modes 0x4 and 0x5 select smart card
// - Card clock out; data pin driven only transmitting
// - Smart card: 8 bits, parity odd or even per mode bit
// - T=0: guard time two bits, undriven
// - Parity error: T=0 NACK state, pin not driven; drop character
// - Error count to 255, clear on read
// - Inhibit NACK: flag, store, no ready
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`include "usbh_defs.vh"
module usbh_top #(
    parameter BAUD_W = 16
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        txd_in,
    output reg         txd_out,
    output reg         txd_oe_n,
    input  wire        rxd,
    input  wire        cts,
    output reg         rts,
    output reg         sck,
    input  wire        dma_rx_full
);
    // Registers
    reg [8:0]        mode_reg;
    reg [BAUD_W-1:0] baud_div;
    reg [7:0]        guard_time;
    reg [7:0]        error_count_field;
    reg [7:0]        tx_holding_reg;
    reg [7:0]        rx_holding_reg;
    reg              tx_hold_full;
    reg              rx_en;
    reg              tx_en;
    reg              rx_char_ready;
    reg              rx_break_flag;
    reg              frame_err;
    reg              parity_error_flag;
    reg              nack_flag;
    reg              rx_buffer_full;
    // Pin synchronisers
    reg [2:0] rx_sy;
    reg [2:0] cts_sy;
    reg       rx_line;
    reg       cts_line;
    // Bus slave
    reg        aw_hold;
    reg        w_hold;
    reg [4:0]  aw_addr;
    reg [31:0] w_data;
    wire       wr_go = aw_hold & w_hold & ~s_axi_bvalid;
    wire       rd_go = s_axi_arvalid & s_axi_arready;
    wire [3:0] op_mode = mode_reg[`USBH_M_MODE_HI:`USBH_M_MODE_LO];
    wire       card = (op_mode == `USBH_MODE_T0) | (op_mode == `USBH_MODE_T1);
    wire       t0 = (op_mode == `USBH_MODE_T0);
    wire       hshake = (op_mode == `USBH_MODE_HSHAKE);
    wire       cwr = wr_go & (aw_addr == `USBH_A_CTRL) & s_axi_wstrb[0];
    wire       cwr1 = wr_go & (aw_addr == `USBH_A_CTRL) & s_axi_wstrb[1];
    wire       thr_wr = wr_go & (aw_addr == `USBH_A_TXHOLD) & s_axi_wstrb[0];
    wire       ner_rd = rd_go & (s_axi_araddr == `USBH_A_ERRCNT);
    wire       clr_sta = cwr & w_data[`USBH_C_CLRSTA];
    // Bit clock: 16 ticks per bit
    reg [BAUD_W-1:0] bdiv;
    wire tick = (bdiv == {BAUD_W{1'b0}});
    always @(posedge aclk) begin
        if (!aresetn) begin
            bdiv <= {BAUD_W{1'b0}};
            sck  <= 1'b0;
        end else begin
            bdiv <= tick ? baud_div : bdiv - 1'b1;
            if (tick)
                sck <= card ? ~sck : 1'b0;
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_sy    <= 3'b111;
            cts_sy   <= 3'b000;
            rx_line  <= 1'b1;
            cts_line <= 1'b0;
        end else begin
            rx_sy  <= {rx_sy[1:0], card ? txd_in : rxd};
            cts_sy <= {cts_sy[1:0], cts};
            if (rx_sy[1] == rx_sy[2])
                rx_line <= rx_sy[2];
            if (cts_sy[1] == cts_sy[2])
                cts_line <= cts_sy[2];
        end
    end
    // Transmitter
    localparam TX_IDLE = 3'd0, TX_SHIFT = 3'd1, TX_BRK = 3'd2, TX_GAP = 3'd3, TX_WAIT = 3'd4;
    reg [2:0]  tx_st;
    reg [3:0]  tx_os;
    reg [3:0]  tx_bit;
    reg [11:0] tx_sr;
    reg [7:0]  tx_gapcnt;
    reg        brk_pend;
    reg        brk_stop;
    reg        brk_min;
    wire       tx_busy = (tx_st != TX_IDLE);
    wire       tx_all_empty = ~tx_busy & ~tx_hold_full;
    wire       tx_holding_free = ~tx_hold_full & ~brk_pend;
    wire       bit_end = tick & (tx_os == `USBH_OS_LAST);
    wire [7:0] gap_len = (guard_time > `USBH_BRK_GAP) ? guard_time : `USBH_BRK_GAP;
    wire [3:0] tx_nbits = card ? (t0 ? 4'd12 : (mode_reg[`USBH_M_STOP2] ? 4'd12 : 4'd11))
                               : (mode_reg[`USBH_M_STOP2] ? 4'd12 : 4'd11);
    wire       stt_ok = cwr & w_data[`USBH_C_STTBK] & tx_holding_free & ~brk_pend
                        & (tx_st != TX_BRK) & (tx_st != TX_GAP);
    function [7:0] usbh_order;
        input [7:0] d;
        input       msb;
        integer     i;
        begin
            for (i = 0; i < 8; i = i + 1)
                usbh_order[i] = msb ? d[7-i] : d[i];
        end
    endfunction
    function usbh_par;
        input [7:0] d;
        input       odd;
        begin
            usbh_par = ^d ^ odd;
        end
    endfunction
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_st     <= TX_IDLE;
            tx_os     <= 4'h0;
            tx_bit    <= 4'h0;
            tx_sr     <= 12'hfff;
            tx_gapcnt <= 8'h00;
            brk_pend  <= 1'b0;
            brk_stop  <= 1'b0;
            brk_min   <= 1'b0;
            txd_out   <= 1'b1;
            txd_oe_n  <= 1'b1;
            tx_hold_full   <= 1'b0;
            tx_holding_reg <= 8'h00;
        end else begin
            if (stt_ok)
                brk_pend <= 1'b1;
            if (cwr & w_data[`USBH_C_STPBK] & (brk_pend | tx_st == TX_BRK) & tx_holding_free)
                brk_stop <= 1'b1;
            if (thr_wr & ~brk_pend & ~tx_hold_full) begin
                tx_holding_reg <= s_axi_wdata[7:0];
                tx_hold_full   <= 1'b1;
            end
            if (tick)
                tx_os <= tx_os + 1'b1;
            case (tx_st)
                TX_IDLE: begin
                    txd_out  <= 1'b1;
                    txd_oe_n <= card;
                    if (bit_end & tx_en) begin
                        if (brk_pend) begin
                            tx_st    <= TX_BRK;
                            brk_pend <= 1'b0;
                            brk_min  <= 1'b0;
                            tx_bit   <= 4'h0;
                        end else if (tx_hold_full & ~(hshake & cts_line)) begin
                            tx_sr  <= {2'b11, usbh_par(tx_holding_reg, mode_reg[`USBH_M_PARODD]),
                                       usbh_order(tx_holding_reg, mode_reg[`USBH_M_MSB_FIRST_SELECT]), 1'b0};
                            tx_hold_full <= 1'b0;
                            tx_bit <= 4'h0;
                            tx_st  <= TX_SHIFT;
                        end
                    end
                end
                TX_SHIFT: begin
                    txd_out  <= tx_sr[0];
                    txd_oe_n <= card & (tx_bit > 4'd9);
                    if (bit_end) begin
                        tx_sr  <= {1'b1, tx_sr[11:1]};
                        tx_bit <= tx_bit + 1'b1;
                        if (tx_bit == tx_nbits - 1'b1) begin
                            tx_gapcnt <= guard_time;
                            tx_st     <= (guard_time != 8'h00) ? TX_WAIT : TX_IDLE;
                        end
                    end
                end
                TX_WAIT: begin
                    txd_out  <= 1'b1;
                    txd_oe_n <= card;
                    if (bit_end) begin
                        tx_gapcnt <= tx_gapcnt - 1'b1;
                        if (tx_gapcnt == 8'h01)
                            tx_st <= TX_IDLE;
                    end
                end
                TX_BRK: begin
                    txd_out  <= 1'b0;
                    txd_oe_n <= 1'b0;
                    if (bit_end) begin
                        if (tx_bit == tx_nbits - 1'b1)
                            brk_min <= 1'b1;
                        else
                            tx_bit <= tx_bit + 1'b1;
                    end
                    if (brk_min & brk_stop & bit_end) begin
                        brk_stop  <= 1'b0;
                        tx_gapcnt <= gap_len;
                        tx_st     <= TX_GAP;
                    end
                end
                TX_GAP: begin
                    txd_out  <= 1'b1;
                    txd_oe_n <= card;
                    if (bit_end) begin
                        tx_gapcnt <= tx_gapcnt - 1'b1;
                        if (tx_gapcnt == 8'h01)
                            tx_st <= TX_IDLE;
                    end
                end
                default: tx_st <= TX_IDLE;
            endcase
        end
    end
    // Receiver
    localparam RX_IDLE = 3'd0, RX_BITS = 3'd1, RX_NACK = 3'd2, RX_BRKW = 3'd3;
    reg [2:0]  rx_st;
    reg [3:0]  rx_os;
    reg [3:0]  rx_bit;
    reg [10:0] rx_sr;
    reg        rx_hicnt_ok;
    wire       rx_mid = tick & (rx_os == `USBH_OS_MID);
    wire       rx_bend = tick & (rx_os == `USBH_OS_LAST);
    wire [7:0] rx_data = usbh_order(rx_sr[9:2], mode_reg[`USBH_M_MSB_FIRST_SELECT]);
    wire       rx_perr = (rx_sr[10] != usbh_par(rx_data, mode_reg[`USBH_M_PARODD]));
    wire       rx_zero = (rx_sr[10:2] == 9'h000) & ~rx_line;
    reg        ev_brk;
    reg        ev_pe;
    reg        ev_fe;
    reg        ev_rdy;
    reg        ev_nacki;
    reg        rx_nack_drv;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_st <= RX_IDLE;
            rx_os <= 4'h0;
            rx_bit <= 4'h0;
            rx_sr <= 11'h000;
            rx_hicnt_ok <= 1'b0;
            ev_brk <= 1'b0;
            ev_pe <= 1'b0;
            ev_fe <= 1'b0;
            ev_rdy <= 1'b0;
            ev_nacki <= 1'b0;
            rx_nack_drv <= 1'b0;
            rx_holding_reg <= 8'h00;
        end else begin
            ev_brk <= 1'b0;
            ev_pe <= 1'b0;
            ev_fe <= 1'b0;
            ev_rdy <= 1'b0;
            ev_nacki <= 1'b0;
            if (tick)
                rx_os <= rx_os + 1'b1;
            case (rx_st)
                RX_IDLE: begin
                    rx_nack_drv <= 1'b0;
                    if (rx_en & ~rx_line & tick) begin
                        rx_os  <= 4'h1;
                        rx_bit <= 4'h0;
                        rx_st  <= RX_BITS;
                    end
                end
                RX_BITS: if (rx_mid) begin
                    rx_sr  <= {rx_line, rx_sr[10:1]};
                    rx_bit <= rx_bit + 1'b1;
                    if (rx_bit == 4'd10) begin
                        if (rx_zero) begin
                            ev_brk <= 1'b1;
                            rx_hicnt_ok <= 1'b0;
                            rx_st <= RX_BRKW;
                        end else if (card & rx_perr) begin
                            ev_pe <= 1'b1;
                            if (mode_reg[`USBH_M_NACK_INHIBIT]) begin
                                ev_nacki <= 1'b1;
                                rx_holding_reg <= rx_data;
                                rx_st <= RX_IDLE;
                            end else begin
                                rx_nack_drv <= t0;
                                rx_st <= t0 ? RX_NACK : RX_IDLE;
                            end
                        end else begin
                            ev_pe <= rx_perr;
                            ev_fe <= ~rx_line;
                            ev_rdy <= 1'b1;
                            rx_holding_reg <= rx_data;
                            rx_st <= RX_IDLE;
                        end
                    end
                end
                RX_NACK: if (rx_bend) begin
                    rx_nack_drv <= 1'b0;
                    rx_st <= RX_IDLE;
                end
                RX_BRKW: begin
                    if (~rx_line)
                        rx_hicnt_ok <= 1'b0;
                    if (rx_line & (mode_reg[`USBH_M_SYNC] | (tick & rx_hicnt_ok))) begin
                        ev_brk <= 1'b1;
                        rx_st  <= RX_IDLE;
                    end else if (rx_line & tick)
                        rx_hicnt_ok <= 1'b1;
                end
                default: rx_st <= RX_IDLE;
            endcase
        end
    end
    // Status, control, error counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_en <= 1'b0;
            tx_en <= 1'b0;
            rx_char_ready <= 1'b0;
            rx_break_flag <= 1'b0;
            frame_err <= 1'b0;
            parity_error_flag <= 1'b0;
            nack_flag <= 1'b0;
            rx_buffer_full <= 1'b0;
            error_count_field <= 8'h00;
            rts <= 1'b0;
        end else begin
            if (cwr & w_data[`USBH_C_RXEN])
                rx_en <= 1'b1;
            if (cwr & w_data[`USBH_C_RXDIS])
                rx_en <= 1'b0;
            if (cwr & w_data[`USBH_C_TXEN])
                tx_en <= 1'b1;
            if (cwr & w_data[`USBH_C_TXDIS])
                tx_en <= 1'b0;
            if (clr_sta) begin
                rx_break_flag <= 1'b0;
                frame_err <= 1'b0;
                parity_error_flag <= 1'b0;
            end
            if (ev_brk)
                rx_break_flag <= 1'b1;
            if (ev_fe)
                frame_err <= 1'b1;
            if (ev_pe)
                parity_error_flag <= 1'b1;
            if (cwr & w_data[`USBH_C_CLRNACK])
                nack_flag <= 1'b0;
            if (ev_nacki)
                nack_flag <= 1'b1;
            if (rd_go & (s_axi_araddr == `USBH_A_RXHOLD))
                rx_char_ready <= 1'b0;
            if (ev_rdy)
                rx_char_ready <= 1'b1;
            if (cwr1 & w_data[`USBH_C_BUFNEW])
                rx_buffer_full <= 1'b0;
            if (dma_rx_full)
                rx_buffer_full <= 1'b1;
            if (ner_rd)
                error_count_field <= 8'h00;
            if (ev_pe | ev_fe) begin
                if (ner_rd | error_count_field != `USBH_ERR_MAX)
                    error_count_field <= (ner_rd ? 8'h00 : error_count_field) + 8'h01;
            end
            rts <= hshake & ~rx_en & rx_buffer_full;
        end
    end
    // AXI4-Lite slave
    wire [31:0] status_reg = {23'h000000, rx_buffer_full, cts_line, nack_flag, tx_all_empty,
                              parity_error_flag, frame_err, rx_break_flag, tx_holding_free,
                              rx_char_ready};
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `USBH_RESP_OK;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `USBH_RESP_OK;
            s_axi_rdata   <= 32'h0000_0000;
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 5'h00;
            w_data  <= 32'h0000_0000;
            mode_reg   <= 9'h000;
            baud_div   <= `USBH_BAUD_RST;
            guard_time <= 8'h00;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr[1:0] != 2'b00 || aw_addr > `USBH_A_ERRCNT)
                                ? `USBH_RESP_ERR : `USBH_RESP_OK;
                if (aw_addr == `USBH_A_MODE) begin
                    if (s_axi_wstrb[0])
                        mode_reg[7:0] <= w_data[7:0];
                    if (s_axi_wstrb[1])
                        mode_reg[8] <= w_data[8];
                end
                if (aw_addr == `USBH_A_BAUD) begin
                    if (s_axi_wstrb[0])
                        baud_div[7:0] <= w_data[7:0];
                    if (s_axi_wstrb[1])
                        baud_div[BAUD_W-1:8] <= w_data[BAUD_W-1:8];
                end
                if (aw_addr == `USBH_A_GUARD && s_axi_wstrb[0])
                    guard_time <= w_data[7:0];
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `USBH_RESP_OK;
                case (s_axi_araddr)
                    `USBH_A_MODE:   s_axi_rdata <= {23'h000000, mode_reg};
                    `USBH_A_STATUS: s_axi_rdata <= status_reg;
                    `USBH_A_RXHOLD: s_axi_rdata <= {24'h000000, rx_holding_reg};
                    `USBH_A_BAUD:   s_axi_rdata <= {{(32-BAUD_W){1'b0}}, baud_div};
                    `USBH_A_GUARD:  s_axi_rdata <= {24'h000000, guard_time};
                    `USBH_A_ERRCNT: s_axi_rdata <= {24'h000000, error_count_field};
                    `USBH_A_CTRL,
                    `USBH_A_TXHOLD: s_axi_rdata <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `USBH_RESP_ERR;
                    end
                endcase
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ---- tb/usbh_monitor.sv ----
// Checker on the transceiver top ports
module usbh_monitor (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        txd_out,
    input logic        txd_oe_n,
    input logic        rts,
    input logic        sck,
    input logic        dma_rx_full
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_bdone; s_axi_bvalid && s_axi_bready; endsequence
    property p_rst; disable iff (1'h0) !aresetn |=> txd_out && txd_oe_n && !rts && !sck; endproperty
    property p_busy; s_wr |=> !s_axi_awready && !s_axi_wready; endproperty
    property p_bans; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
    property p_brel; s_bdone |=> !s_axi_bvalid && s_axi_awready && s_axi_wready; endproperty
    property p_bstd; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_rstd; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_rts; $rose(rts) |-> dma_rx_full; endproperty
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
    a_busy: assert property (p_busy) else $error("write not busy");
    a_bans: assert property (p_bans) else $error("no write response");
    a_brel: assert property (p_brel) else $error("write not released");
    a_bstd: assert property (p_bstd) else $error("bvalid dropped");
    a_rans: assert property (p_rans) else $error("no read response");
    a_rstd: assert property (p_rstd) else $error("read data moved");
    a_rts: assert property (p_rts) else $error("rts without full buffer");
endmodule
bind usbh_top usbh_monitor u_mon (.*);

// ---- tb/usbh_peer.sv ----
// Remote serial device driving the shared data line
module usbh_peer #(parameter int BIT_NS = 640) (
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line = 1'h1;
    // Bits go out LSB first, then the line is driven high again
    task automatic send(input logic [13:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line <= f[i];
            #(BIT_NS);
        end
        line <= 1'h1;
    endtask
endmodule

// ---- tb/usart_break_handshake_iso7816_test.sv ----
// Self-checking bench for the serial transceiver top
`include "usbh_defs.vh"
module usart_break_handshake_iso7816_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
    logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic        cts = '0, dma_rx_full = '0, prv = '1;
    logic [4:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, rd_d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  rd_r;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         txd_out, txd_oe_n, rts, sck, line, txd_in, rxd;
    int          error_cnt = 0, checks = 0, wd = 0, t0, lo = 0, hi = 0;
    int          lo_last, hi_last, nf = 0, sk = 0;
    logic [38:0] rows [5] = '{{`USBH_A_BAUD, 32'h0000_000a, `USBH_RESP_OK},
        {`USBH_A_ERRCNT, 32'h0000_0000, `USBH_RESP_OK},
        {`USBH_A_MODE, 32'h0000_0000, `USBH_RESP_OK},
        {5'h02, 32'h0000_0000, `USBH_RESP_ERR}, {5'h1e, 32'h0000_0000, `USBH_RESP_ERR}};
    assign txd_in = txd_oe_n ? line : txd_out;
    assign rxd    = line;
    usbh_top uut (.*);
    usbh_peer peer (.line(line));
    always #20 aclk = ~aclk;
    // Run lengths and falls on the transmit pin
    always @(posedge aclk) begin
        lo  <= txd_out ? 0 : lo + 1;
        hi  <= txd_out ? hi + 1 : 0;
        prv <= txd_out;
        sk  <= sk + int'(sck);
        if (txd_out && !prv)
            lo_last <= lo;
        if (!txd_out && prv) begin
            hi_last <= hi;
            nf      <= nf + 1;
        end
    end
    task automatic complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tk;
        @(posedge aclk);
        wd++;
        if (wd > 20000) begin
            error_cnt++;
            complete_run;
        end
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 0;
        dd = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        while (!(ad && dd)) begin
            tk;
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (!dd && s_axi_wready) begin
                dd = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        s_axi_bready <= 1'h1;
        do tk; while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        do tk; while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        s_axi_rready  <= 1'h1;
        do tk; while (s_axi_rvalid !== 1'h1);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic poll(input int b);
        do rd(`USBH_A_STATUS); while (rd_d[b] !== 1'h1);
    endtask
    task automatic until_txd(input logic v);
        do tk; while (txd_out !== v);
    endtask
    initial begin
        repeat (12) tk;
        aresetn <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            rd(rows[i][38:34]);
            chk({rd_d, rd_r}, rows[i][33:0]);
        end
        wr(`USBH_A_BAUD, 32'h0000_0000);
        wr(`USBH_A_CTRL, 32'h0000_0005);
        peer.send({1'h1, 1'h0, 8'h01, 1'h0}, 11);
        repeat (32) tk;
        rd(`USBH_A_STATUS);
        chk(rd_d[`USBH_S_PARITY_ERROR_FLAG], 1'h1);
        rd(`USBH_A_ERRCNT);
        chk(rd_d, 32'h0000_0001);
        rd(`USBH_A_ERRCNT);
        chk(rd_d, 32'h0000_0000);
        wr(`USBH_A_CTRL, 32'h0000_0008);
        wr(`USBH_A_MODE, 32'h0000_0005);
        peer.send({1'h1, 1'h0, 8'ha5, 1'h0}, 11);
        repeat (32) tk;
        rd(`USBH_A_RXHOLD);
        chk(rd_d, 32'h0000_00a5);
        chk(sk > 0, 1'h1);
        wr(`USBH_A_MODE, 32'h0000_0000);
        wr(`USBH_A_CTRL, 32'h0000_0004);
        wr(`USBH_A_CTRL, 32'h0000_0020);
        until_txd(1'h0);
        rd(`USBH_A_STATUS);
        chk(rd_d[`USBH_S_TX_ALL_EMPTY], 1'h0);
        poll(`USBH_S_TX_HOLDING_FREE);
        wr(`USBH_A_CTRL, 32'h0000_0040);
        poll(`USBH_S_TX_HOLDING_FREE);
        wr(`USBH_A_TXHOLD, 32'h0000_0055);
        until_txd(1'h1);
        until_txd(1'h0);
        tk;
        chk(lo_last >= 176, 1'h1);
        chk(hi_last >= 192, 1'h1);
        fork
            peer.send(14'h0000, 14);
        join_none
        repeat (200) tk;
        rd(`USBH_A_STATUS);
        chk(rd_d & 32'h0000_000c, 32'h0000_0004);
        wr(`USBH_A_CTRL, 32'h0000_0010);
        rd(`USBH_A_STATUS);
        chk(rd_d[`USBH_S_RX_BREAK_FLAG], 1'h0);
        do tk; while (line !== 1'h1);
        repeat (16) tk;
        rd(`USBH_A_STATUS);
        chk(rd_d[`USBH_S_RX_BREAK_FLAG], 1'h1);
        wr(`USBH_A_MODE, 32'h0000_0002);
        wr(`USBH_A_CTRL, 32'h0000_0002);
        dma_rx_full <= 1'h1;
        repeat (8) tk;
        chk(rts, 1'h1);
        wr(`USBH_A_CTRL, 32'h0000_0001);
        repeat (8) tk;
        chk(rts, 1'h0);
        wr(`USBH_A_CTRL, 32'h0000_0002);
        repeat (8) tk;
        dma_rx_full <= 1'h0;
        wr(`USBH_A_CTRL, 32'h0000_0100);
        repeat (8) tk;
        chk(rts, 1'h0);
        cts <= 1'h1;
        repeat (8) tk;
        t0 = nf;
        wr(`USBH_A_TXHOLD, 32'h0000_000f);
        repeat (400) tk;
        chk(nf - t0, 0);
        t0 = wd;
        cts <= 1'h0;
        until_txd(1'h0);
        chk(wd - t0 < 40, 1'h1);
        complete_run;
    end
endmodule
